// ===== pkg/flash_host_pkg.sv
// shared constants, register map and state types for the flash host controller
package flash_host_pkg;

	// ==========================================================
	// clock and pin timing
	localparam int CLK_PERIOD_NS   = 5;
	localparam int WR_SETUP_NS     = 20;
	localparam int WR_PULSE_NS     = 50;
	localparam int WR_RECOVER_NS   = 30;
	localparam int RD_ACCESS_NS    = 90;
	localparam int BUSY_SEEN_NS    = 200;
	localparam int WAKE_TO_READ_NS = 600;
	localparam int WAKE_TO_WRITE_NS = 1000;
	localparam int SYNC_LAG_CYC    = 3;

	localparam int WR_SETUP_CYC  = (WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_PULSE_CYC  = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_RECOVER_CYC = (WR_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_SAMPLE_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAG_CYC;
	localparam int BUSY_SEEN_CYC = (BUSY_SEEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAG_CYC;
	localparam int WAKE_TO_READ_CYC = (WAKE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_TO_WRITE_CYC = (WAKE_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int TIMER_W = 16;
	localparam int ADDR_W  = 20;
	localparam int DATA_W  = 16;

	// ==========================================================
	// device command words
	localparam logic [15:0] CMD_READ_ARRAY    = 16'h00FF;
	localparam logic [15:0] CMD_READ_STATUS   = 16'h0070;
	localparam logic [15:0] CMD_CLEAR_STATUS  = 16'h0050;
	localparam logic [15:0] CMD_ERASE_SETUP   = 16'h0020;
	localparam logic [15:0] CMD_ERASE_CONFIRM = 16'h00D0;
	localparam logic [15:0] CMD_PROGRAM_SETUP = 16'h0040;

	// device status word bit positions
	localparam int DEV_READY_BIT  = 7;
	localparam int DEV_ERASE_BIT  = 5;
	localparam int DEV_PROG_BIT   = 4;
	localparam int DEV_SUPPLY_BIT = 3;

	// ==========================================================
	// software register map (byte addresses)
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_ADDR   = 5'h04;
	localparam logic [4:0] REG_WDATA  = 5'h08;
	localparam logic [4:0] REG_RDATA  = 5'h0C;
	localparam logic [4:0] REG_STATUS = 5'h10;

	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_START_BIT = 3;
	localparam int CTRL_PD_BIT   = 4;

	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_PIN_RDY_BIT  = 1;
	localparam int ST_PD_BIT       = 2;
	localparam int ST_NEED_RA_BIT  = 3;
	localparam int ST_ABORT_BIT    = 4;
	localparam int ST_MRDY_BIT     = 5;
	localparam int ST_EERR_BIT     = 6;
	localparam int ST_PERR_BIT     = 7;
	localparam int ST_SUPPLY_BIT   = 8;
	localparam int ST_IMPROPER_BIT = 9;
	localparam int ST_WR_OK_BIT    = 10;

	// ==========================================================
	// operations and sequencer states
	typedef enum logic [2:0] {OP_READ, OP_PROGRAM, OP_ERASE, OP_STATUS, OP_CLEAR} op_e;

	typedef enum logic [3:0] {
		P_PD, P_WAKE, P_IDLE, P_WSET, P_WLOW, P_WREC, P_BUSY, P_RSET, P_RDONE
	} phase_e;

endpackage

// ===== sim/flash_dev_model.sv
// behavioural flash device on the far side of the host pins
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int BUSY_NS = 2000
) (
	input  wire logic        ce_n,    // chip select
	input  wire logic        we_n,    // write strobe
	input  wire logic        oe_n,    // output enable
	input  wire logic        rp_n,    // reset/power-down
	input  wire logic [15:0] din,     // host data
	input  wire logic        vpp_bad, // supply fault
	output logic      [15:0] dout,    // data to host
	output logic             rdy      // ready pin after pull-up
);
	logic [15:0] stat = '0;
	logic [15:0] mem = '0;
	logic [15:0] prev = '0;
	logic [15:0] val;
	logic        busy = 1'b0;
	logic        rd_arr = 1'b1;
	assign rdy = !busy;
	assign val = rd_arr ? mem : {8'h00, !busy, stat[6:0]};
	// deselected pins show the inverted value, not the value itself
	assign dout = (!ce_n && !oe_n && rp_n) ? val : ~val;
	// ==========================================
	// command latch: taken while strobe and select are both low
	always @(negedge we_n)
	begin : cmd
		if (ce_n === 1'b0 && rp_n === 1'b1)
		begin
			if (prev == 16'h0040 || prev == 16'h0020)
			begin
				rd_arr = 1'b0;
				busy = prev == 16'h0040 || din == 16'h00D0;
				if (!busy)
					stat[5:4] = 2'b11;
				if (busy && prev == 16'h0040)
					mem = din;
				#(BUSY_NS);
				if (busy && vpp_bad)
					stat[5:3] = {prev == 16'h0020, prev == 16'h0040, 1'b1};
				busy = 1'b0;
				prev = '0;
			end
			else if (din == 16'h00FF)
				rd_arr = 1'b1;
			else if (din == 16'h0050)
				stat = '0;
			else
			begin
				rd_arr = 1'b0;
				prev = din;
			end
		end
	end
	// internal reset keeps the pin low a while before the abort
	always @(negedge rp_n)
	begin
		#40;
		disable cmd;
		{busy, stat, prev, rd_arr} = {1'b0, 32'h0000_0000, 1'b1};
	end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_top;
	logic        clk = 0, rst_n = 0, rd = 0, wr = 0, vpp_bad = 0;
	logic [4:0]  adr = '0;
	logic [31:0] wd = '0, rdat, s;
	logic        wq, ce_n, we_n, oe_n, rp_n, rdy, oe;
	logic [15:0] dq_o, dq_i;
	logic [19:0] fa;
	int          num_errors = 0, cmp_count = 0, cyc = 0, nlow = 0;
	always #2.5 clk = ~clk;
	always @(negedge rdy) nlow++;
	flash_host_ctrl dut_u (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wq), .flash_addr(fa),
		.flash_dq_in(dq_i), .flash_dq_out(dq_o), .flash_dq_oe(oe), .flash_ce_n(ce_n), .flash_we_n(we_n),
		.flash_oe_n(oe_n), .reset_powerdown_in_n(rp_n), .op_done_open_drain_out(rdy));
	// undriven data pins show the inverse, so a missing output enable corrupts the command
	flash_dev_model mdl_u (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .rp_n(rp_n), .din(oe ? dq_o : ~dq_o),
		.vpp_bad(vpp_bad), .dout(dq_i), .rdy(rdy));
	// ==========================================
	// bus access and checks
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do
			@(posedge clk);
		while (wq !== 1'b0);
		s = rdat;
		wr <= 0;
		rd <= 0;
	endtask
	task automatic ctl(input logic [4:0] v);
		acc(1, flash_host_pkg::REG_CTRL, {27'h0, v});
	endtask
	task automatic poll(input int b, input logic v);
		do acc(0, flash_host_pkg::REG_STATUS, 0);
		while (s[b] !== v);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			finish_test;
		end
	end
	// ==========================================
	// tests
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		poll(10, 1);
		acc(1, flash_host_pkg::REG_ADDR, 32'h0001_2345);
		acc(1, flash_host_pkg::REG_WDATA, 32'h0000_BEEF);
		ctl(5'h09);
		poll(0, 0);
		chk("program flags", 6'b00_0101, s[8:3]);
		chk("busy pulses", 1, nlow);
		chk("flash address", 32'h0001_2345, {12'h000, fa});
		ctl(5'h08);
		poll(0, 0);
		acc(0, flash_host_pkg::REG_RDATA, 0);
		chk("array word", 32'h0000_BEEF, s);
		$display("test program and read done");
		vpp_bad <= 1;
		ctl(5'h0A);
		poll(0, 0);
		chk("supply fault", 5'b0_1011, s[9:5]);
		vpp_bad <= 0;
		ctl(5'h0C);
		poll(0, 0);
		ctl(5'h0B);
		poll(0, 0);
		chk("cleared flags", 4'b0001, s[8:5]);
		ctl(5'h10);
		ctl(5'h19);
		acc(0, flash_host_pkg::REG_STATUS, 0);
		chk("powered down", 6'b00_0011, {s[8:6], s[4], s[2], s[1]});
		chk("refused start", 2, nlow);
		$display("test fault and power-down done");
		ctl(5'h00);
		poll(10, 1);
		ctl(5'h0A);
		@(negedge rdy);
		ctl(5'h10);
		poll(2, 1);
		chk("abort", 2'b11, {s[4], s[2]});
		acc(1, flash_host_pkg::REG_STATUS, 32'h0000_0010);
		acc(0, flash_host_pkg::REG_STATUS, 0);
		chk("abort clear", 0, s[4]);
		ctl(5'h00);
		poll(10, 1);
		ctl(5'h0A);
		poll(0, 0);
		chk("erase redo", 4'b0001, s[8:5]);
		$display("test abort done");
		finish_test;
	end
endmodule

// ===== src/cycle_timer.sv
// loadable down counter; done is high once the loaded count has run out
`timescale 1ns/1ps
module cycle_timer (
	input  wire logic                              clk,    // system clock
	input  wire logic                              rst_n,  // async reset, active low
	input  wire logic                              load,   // restart with value
	input  wire logic [flash_host_pkg::TIMER_W-1:0] value, // cycles until done
	output logic                                   done    // count exhausted
);
	logic [flash_host_pkg::TIMER_W-1:0] count_ff, nxt_count;

	always_comb
	begin
		if (load)
			nxt_count = value;
		else if (count_ff != '0)
			nxt_count = count_ff - 1'b1;
		else
			nxt_count = count_ff;
	end

	// resets to all ones so nothing counts as elapsed for 65535 cycles after reset unless loaded first
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_ff <= '1;
		else
			count_ff <= nxt_count;
	end

	assign done = (count_ff == '0);
endmodule

// ===== src/flash_host_ctrl.sv
// host-side controller driving a parallel flash through its pins, with an Avalon-MM register slave
`timescale 1ns/1ps
module flash_host_ctrl (
	input  wire logic        clk,                    // 200 MHz clock
	input  wire logic        rst_n,                  // async reset, active low
	input  wire logic [4:0]  avs_address,            // byte address
	input  wire logic        avs_read,               // read request
	input  wire logic        avs_write,              // write request
	input  wire logic [31:0] avs_writedata,          // write data
	input  wire logic [3:0]  avs_byteenable,         // byte lanes
	output logic      [31:0] avs_readdata,           // read data
	output logic             avs_waitrequest,        // stall
	output logic      [19:0] flash_addr,             // flash address
	input  wire logic [15:0] flash_dq_in,            // data pins, in
	output logic      [15:0] flash_dq_out,           // data pins, out
	output logic             flash_dq_oe,            // data pins driven
	output logic             flash_ce_n,             // chip select
	output logic             flash_we_n,             // write strobe
	output logic             flash_oe_n,             // output enable
	output logic             reset_powerdown_in_n,   // reset/power-down pin
	input  wire logic        op_done_open_drain_out  // ready/busy pin via pull-up
);
	// ==========================================================
	// helpers
	function automatic logic [1:0] write_count(flash_host_pkg::op_e op, logic need_ra);
		case (op)
			flash_host_pkg::OP_PROGRAM: write_count = 2'd2;
			flash_host_pkg::OP_ERASE:   write_count = 2'd2;
			flash_host_pkg::OP_READ:    write_count = need_ra ? 2'd1 : 2'd0;
			default:                    write_count = 2'd1;
		endcase
	endfunction

	function automatic logic [15:0] cmd_word(flash_host_pkg::op_e op, logic [1:0] idx, logic [15:0] data);
		case (op)
			flash_host_pkg::OP_PROGRAM: cmd_word = (idx == 2'd0) ? flash_host_pkg::CMD_PROGRAM_SETUP : data;
			flash_host_pkg::OP_ERASE:   cmd_word = (idx == 2'd0) ? flash_host_pkg::CMD_ERASE_SETUP
			                                                     : flash_host_pkg::CMD_ERASE_CONFIRM;
			flash_host_pkg::OP_STATUS:  cmd_word = flash_host_pkg::CMD_READ_STATUS;
			flash_host_pkg::OP_CLEAR:   cmd_word = flash_host_pkg::CMD_CLEAR_STATUS;
			default:                    cmd_word = flash_host_pkg::CMD_READ_ARRAY;
		endcase
	endfunction

	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// ==========================================================
	// pin inputs and timers
	logic        rdy_pin;
	logic [15:0] dq_sync;
	logic        ph_load, ph_done, wake_load, rd_wake_done, wr_wake_done;
	logic [flash_host_pkg::TIMER_W-1:0] ph_val;

	pin_sync #(.W(1)) u_rdy_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (op_done_open_drain_out),
		.level (rdy_pin)
	);
	pin_sync #(.W(16)) u_dq_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (flash_dq_in),
		.level (dq_sync)
	);
	cycle_timer u_phase_tmr (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (ph_load),
		.value (ph_val),
		.done  (ph_done)
	);
	cycle_timer u_wake_rd_tmr (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (wake_load),
		.value (flash_host_pkg::TIMER_W'(flash_host_pkg::WAKE_TO_READ_CYC)),
		.done  (rd_wake_done)
	);
	cycle_timer u_wake_wr_tmr (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (wake_load),
		.value (flash_host_pkg::TIMER_W'(flash_host_pkg::WAKE_TO_WRITE_CYC)),
		.done  (wr_wake_done)
	);

	// ==========================================================
	// software registers
	flash_host_pkg::op_e req_op_ff, nxt_req_op;
	logic        pd_req_ff, nxt_pd_req;
	logic [19:0] addr_reg_ff, nxt_addr_reg;
	logic [15:0] wdata_reg_ff, nxt_wdata_reg;
	logic        rd_valid_ff, nxt_rd_valid;
	logic [31:0] rdata_bus_ff, nxt_rdata_bus;
	logic        wr_ctrl, start_req, can_start, start_go, wr_ok, abort_clr;
	logic [31:0] status_word, ctrl_word;

	// sequencer state
	flash_host_pkg::phase_e phase_ff, nxt_phase;
	flash_host_pkg::op_e    op_ff, nxt_op;
	logic [1:0]  wcnt_ff, nxt_wcnt, wtot_ff, nxt_wtot, pulses_ff, nxt_pulses;
	logic        seen_ff, nxt_seen, need_ra_ff, nxt_need_ra, aborted_ff, nxt_aborted;
	logic [3:0]  flags_ff, nxt_flags;
	logic [15:0] rdata_ff, nxt_rdata;
	logic [19:0] op_addr_ff, nxt_op_addr;
	logic        ce_n_ff, we_n_ff, oe_n_ff, rp_n_ff, dq_oe_ff;
	logic        nxt_ce_n, nxt_we_n, nxt_oe_n, nxt_rp_n, nxt_dq_oe;
	logic [15:0] dq_out_ff, nxt_dq_out;

	assign wr_ok     = wr_wake_done && phase_ff != flash_host_pkg::P_PD && phase_ff != flash_host_pkg::P_WAKE;
	assign wr_ctrl   = avs_write && avs_address == flash_host_pkg::REG_CTRL && avs_byteenable[0];
	assign start_req = wr_ctrl && avs_writedata[flash_host_pkg::CTRL_START_BIT];
	assign can_start = phase_ff == flash_host_pkg::P_IDLE && wr_ok && !pd_req_ff;
	assign start_go  = start_req && can_start;
	assign abort_clr = avs_write && avs_address == flash_host_pkg::REG_STATUS && avs_byteenable[0]
	                   && avs_writedata[flash_host_pkg::ST_ABORT_BIT];
	// a start is held off until the sequencer is idle and the wake-to-write delay has run out; while power-down is requested it is dropped instead
	assign avs_waitrequest = (avs_read && !rd_valid_ff) ||
	                         (start_req && !can_start && !pd_req_ff && !avs_writedata[flash_host_pkg::CTRL_PD_BIT]);
	assign avs_readdata = rdata_bus_ff;

	always_comb
	begin
		ctrl_word = '0;
		ctrl_word[flash_host_pkg::CTRL_OP_LSB +: 3] = req_op_ff;
		ctrl_word[flash_host_pkg::CTRL_PD_BIT]      = pd_req_ff;
		status_word = '0;
		status_word[flash_host_pkg::ST_BUSY_BIT]    = phase_ff != flash_host_pkg::P_IDLE;
		status_word[flash_host_pkg::ST_PIN_RDY_BIT] = rdy_pin;
		status_word[flash_host_pkg::ST_PD_BIT]      = !rp_n_ff;
		status_word[flash_host_pkg::ST_NEED_RA_BIT] = need_ra_ff;
		status_word[flash_host_pkg::ST_ABORT_BIT]   = aborted_ff;
		status_word[flash_host_pkg::ST_MRDY_BIT +: 4] = flags_ff;
		status_word[flash_host_pkg::ST_IMPROPER_BIT] = flags_ff[1] && flags_ff[2];
		status_word[flash_host_pkg::ST_WR_OK_BIT]   = wr_ok;

		nxt_req_op    = req_op_ff;
		nxt_pd_req    = pd_req_ff;
		nxt_addr_reg  = addr_reg_ff;
		nxt_wdata_reg = wdata_reg_ff;
		nxt_rd_valid  = avs_read && !rd_valid_ff;
		nxt_rdata_bus = rdata_bus_ff;
		if (wr_ctrl && !avs_waitrequest)
		begin
			nxt_req_op = flash_host_pkg::op_e'(avs_writedata[flash_host_pkg::CTRL_OP_LSB +: 3]);
			nxt_pd_req = avs_writedata[flash_host_pkg::CTRL_PD_BIT];
		end
		if (avs_write && avs_address == flash_host_pkg::REG_ADDR)
			nxt_addr_reg = 20'(merge({12'h000, addr_reg_ff}, avs_writedata, avs_byteenable));
		if (avs_write && avs_address == flash_host_pkg::REG_WDATA)
			nxt_wdata_reg = 16'(merge({16'h0000, wdata_reg_ff}, avs_writedata, avs_byteenable));
		if (avs_read && !rd_valid_ff)
		begin
			case (avs_address)
				flash_host_pkg::REG_CTRL:   nxt_rdata_bus = ctrl_word;
				flash_host_pkg::REG_ADDR:   nxt_rdata_bus = {12'h000, addr_reg_ff};
				flash_host_pkg::REG_WDATA:  nxt_rdata_bus = {16'h0000, wdata_reg_ff};
				flash_host_pkg::REG_RDATA:  nxt_rdata_bus = {16'h0000, rdata_ff};
				flash_host_pkg::REG_STATUS: nxt_rdata_bus = status_word;
				default:                    nxt_rdata_bus = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// command sequencer
	always_comb
	begin
		nxt_phase   = phase_ff;
		nxt_op      = op_ff;
		nxt_wcnt    = wcnt_ff;
		nxt_wtot    = wtot_ff;
		nxt_pulses  = pulses_ff;
		nxt_seen    = seen_ff;
		nxt_need_ra = need_ra_ff;
		nxt_flags   = flags_ff;
		nxt_rdata   = rdata_ff;
		nxt_op_addr = op_addr_ff;
		nxt_aborted = aborted_ff && !abort_clr;
		ph_load     = 1'b0;
		ph_val      = '0;
		case (phase_ff)
			flash_host_pkg::P_PD:
			begin
				if (!pd_req_ff)
					nxt_phase = flash_host_pkg::P_WAKE;
			end
			flash_host_pkg::P_WAKE:
			begin
				if (rd_wake_done)
					nxt_phase = flash_host_pkg::P_IDLE;
			end
			flash_host_pkg::P_IDLE:
			begin
				if (start_go)
				begin
					// op written together with start takes effect at once
					nxt_op      = nxt_req_op;
					nxt_op_addr = addr_reg_ff;
					nxt_wcnt    = 2'd0;
					nxt_pulses  = 2'd0;
					nxt_wtot    = write_count(nxt_req_op, need_ra_ff);
					ph_load     = 1'b1;
					if (nxt_wtot == 2'd0)
					begin
						nxt_phase = flash_host_pkg::P_RSET;
						ph_val    = flash_host_pkg::TIMER_W'(flash_host_pkg::RD_SAMPLE_CYC);
					end
					else
					begin
						nxt_phase = flash_host_pkg::P_WSET;
						ph_val    = flash_host_pkg::TIMER_W'(flash_host_pkg::WR_SETUP_CYC);
					end
				end
				else if (pd_req_ff)
					nxt_phase = flash_host_pkg::P_PD;
			end
			flash_host_pkg::P_WSET:
			begin
				if (ph_done)
				begin
					nxt_phase = flash_host_pkg::P_WLOW;
					ph_load   = 1'b1;
					ph_val    = flash_host_pkg::TIMER_W'(flash_host_pkg::WR_PULSE_CYC);
				end
			end
			flash_host_pkg::P_WLOW:
			begin
				if (ph_done)
				begin
					nxt_phase  = flash_host_pkg::P_WREC;
					nxt_pulses = pulses_ff + 2'd1;
					ph_load    = 1'b1;
					ph_val     = flash_host_pkg::TIMER_W'(flash_host_pkg::WR_RECOVER_CYC);
				end
			end
			flash_host_pkg::P_WREC:
			begin
				if (ph_done)
				begin
					ph_load = 1'b1;
					if (wcnt_ff + 2'd1 < wtot_ff)
					begin
						// second cycle of a two-cycle sequence
						nxt_wcnt  = wcnt_ff + 2'd1;
						nxt_phase = flash_host_pkg::P_WSET;
						ph_val    = flash_host_pkg::TIMER_W'(flash_host_pkg::WR_SETUP_CYC);
					end
					else if (op_ff == flash_host_pkg::OP_PROGRAM || op_ff == flash_host_pkg::OP_ERASE)
					begin
						nxt_phase = flash_host_pkg::P_BUSY;
						nxt_seen  = 1'b0;
						ph_val    = flash_host_pkg::TIMER_W'(flash_host_pkg::BUSY_SEEN_CYC);
					end
					else if (op_ff == flash_host_pkg::OP_CLEAR)
					begin
						nxt_flags = 4'h0;
						nxt_phase = flash_host_pkg::P_IDLE;
					end
					else
					begin
						if (op_ff == flash_host_pkg::OP_READ)
							nxt_need_ra = 1'b0;
						nxt_phase = flash_host_pkg::P_RSET;
						ph_val    = flash_host_pkg::TIMER_W'(flash_host_pkg::RD_SAMPLE_CYC);
					end
				end
			end
			flash_host_pkg::P_BUSY:
			begin
				if (!rdy_pin)
					nxt_seen = 1'b1;
				if (pd_req_ff)
				begin
					// dropping reset mid-operation aborts it; software must reissue the sequence
					nxt_aborted = 1'b1;
					nxt_phase   = flash_host_pkg::P_PD;
				end
				else if (rdy_pin && (seen_ff || ph_done))
				begin
					// device sits in status mode afterwards, so the next read fetches its status
					nxt_op      = flash_host_pkg::OP_STATUS;
					nxt_need_ra = 1'b1;
					nxt_phase   = flash_host_pkg::P_RSET;
					ph_load     = 1'b1;
					ph_val      = flash_host_pkg::TIMER_W'(flash_host_pkg::RD_SAMPLE_CYC);
				end
			end
			flash_host_pkg::P_RSET:
			begin
				if (ph_done)
				begin
					nxt_rdata = dq_sync;
					if (op_ff == flash_host_pkg::OP_STATUS)
						nxt_flags = {dq_sync[flash_host_pkg::DEV_SUPPLY_BIT], dq_sync[flash_host_pkg::DEV_PROG_BIT],
						             dq_sync[flash_host_pkg::DEV_ERASE_BIT], dq_sync[flash_host_pkg::DEV_READY_BIT]};
					nxt_phase = flash_host_pkg::P_RDONE;
				end
			end
			flash_host_pkg::P_RDONE:
				nxt_phase = flash_host_pkg::P_IDLE;
			default:
				nxt_phase = flash_host_pkg::P_IDLE;
		endcase
		if (nxt_phase == flash_host_pkg::P_PD)
		begin
			// device clears its status and returns to read-array mode, mirror that
			nxt_flags   = 4'h0;
			nxt_need_ra = 1'b0;
		end
		wake_load = phase_ff == flash_host_pkg::P_PD && nxt_phase == flash_host_pkg::P_WAKE;
		nxt_rp_n  = nxt_phase != flash_host_pkg::P_PD;
		nxt_ce_n  = !(nxt_phase == flash_host_pkg::P_WSET || nxt_phase == flash_host_pkg::P_WLOW ||
		              nxt_phase == flash_host_pkg::P_RSET);
		nxt_we_n  = nxt_phase != flash_host_pkg::P_WLOW;
		nxt_oe_n  = nxt_phase != flash_host_pkg::P_RSET;
		nxt_dq_oe = nxt_phase == flash_host_pkg::P_WSET || nxt_phase == flash_host_pkg::P_WLOW ||
		            nxt_phase == flash_host_pkg::P_WREC;
		nxt_dq_out = cmd_word(nxt_op, nxt_wcnt, wdata_reg_ff);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_op_ff    <= flash_host_pkg::OP_READ;
			pd_req_ff    <= 1'b0;
			addr_reg_ff  <= '0;
			wdata_reg_ff <= '0;
			rd_valid_ff  <= 1'b0;
			rdata_bus_ff <= '0;
			phase_ff     <= flash_host_pkg::P_PD;
			op_ff        <= flash_host_pkg::OP_READ;
			wcnt_ff      <= '0;
			wtot_ff      <= '0;
			pulses_ff    <= '0;
			seen_ff      <= 1'b0;
			need_ra_ff   <= 1'b0;
			aborted_ff   <= 1'b0;
			flags_ff     <= '0;
			rdata_ff     <= '0;
			op_addr_ff   <= '0;
			ce_n_ff      <= 1'b1;
			we_n_ff      <= 1'b1;
			oe_n_ff      <= 1'b1;
			rp_n_ff      <= 1'b0;
			dq_oe_ff     <= 1'b0;
			dq_out_ff    <= '0;
		end
		else
		begin
			req_op_ff    <= nxt_req_op;
			pd_req_ff    <= nxt_pd_req;
			addr_reg_ff  <= nxt_addr_reg;
			wdata_reg_ff <= nxt_wdata_reg;
			rd_valid_ff  <= nxt_rd_valid;
			rdata_bus_ff <= nxt_rdata_bus;
			phase_ff     <= nxt_phase;
			op_ff        <= nxt_op;
			wcnt_ff      <= nxt_wcnt;
			wtot_ff      <= nxt_wtot;
			pulses_ff    <= nxt_pulses;
			seen_ff      <= nxt_seen;
			need_ra_ff   <= nxt_need_ra;
			aborted_ff   <= nxt_aborted;
			flags_ff     <= nxt_flags;
			rdata_ff     <= nxt_rdata;
			op_addr_ff   <= nxt_op_addr;
			ce_n_ff      <= nxt_ce_n;
			we_n_ff      <= nxt_we_n;
			oe_n_ff      <= nxt_oe_n;
			rp_n_ff      <= nxt_rp_n;
			dq_oe_ff     <= nxt_dq_oe;
			dq_out_ff    <= nxt_dq_out;
		end
	end

	assign flash_addr           = op_addr_ff;
	assign flash_dq_out         = dq_out_ff;
	assign flash_dq_oe          = dq_oe_ff;
	assign flash_ce_n           = ce_n_ff;
	assign flash_we_n           = we_n_ff;
	assign flash_oe_n           = oe_n_ff;
	assign reset_powerdown_in_n = rp_n_ff;

	// ==========================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_pd_entry;
		$fell(rp_n_ff);
	endsequence

	a_pd_no_strobe: assert property (!rp_n_ff |-> we_n_ff && ce_n_ff && oe_n_ff)
		else $error("strobe active while device held in power-down");
	a_we_with_ce: assert property (!we_n_ff |-> !ce_n_ff && oe_n_ff)
		else $error("write strobe without chip select or with output enable");
	a_two_cycles: assert property ($rose(phase_ff == flash_host_pkg::P_BUSY) |-> pulses_ff == 2'd2)
		else $error("busy wait entered without two write cycles");
	a_pd_clears: assert property (s_pd_entry |-> flags_ff == 4'h0 && !need_ra_ff)
		else $error("status shadow not cleared on power-down");
	a_read_after_wake: assert property (!oe_n_ff |-> rd_wake_done)
		else $error("read before wake-to-read delay");
	a_write_after_wake: assert property (!we_n_ff |-> wr_wake_done)
		else $error("write strobe before wake-to-write delay");
	a_ra_first: assert property ($rose(phase_ff == flash_host_pkg::P_RSET) && op_ff == flash_host_pkg::OP_READ
		|-> !need_ra_ff)
		else $error("array read without read-array command");
	a_abort_marked: assert property (phase_ff == flash_host_pkg::P_BUSY && pd_req_ff |=> aborted_ff && !rp_n_ff)
		else $error("abort not flagged or reset not lowered");
	a_busy_waits: assert property (phase_ff == flash_host_pkg::P_BUSY && seen_ff && !rdy_pin && !pd_req_ff
		|=> phase_ff == flash_host_pkg::P_BUSY)
		else $error("left busy wait while ready pin low");
	a_wake_timer: assert property ($rose(rp_n_ff) |-> !rd_wake_done [*8])
		else $error("wake delay not restarted on reset release");
endmodule

// ===== src/pin_sync.sv
// three-stage pin synchroniser; output moves once the last two stages agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,    // system clock
	input  wire logic         rst_n,  // async reset, active low
	input  wire logic [W-1:0] pin,    // raw pin level
	output logic      [W-1:0] level   // filtered level
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, level_ff;
	logic [W-1:0] nxt_level;

	always_comb
	begin
		for (int i = 0; i < W; i++)
			nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_ff    <= '0;
			s2_ff    <= '0;
			s3_ff    <= '0;
			level_ff <= '0;
		end
		else
		begin
			s1_ff    <= pin;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

	assign level = level_ff;
endmodule
